// [rtl/bsp_pkg.sv]
// shared constants and types of the scan test and programming port
// assumes one 100 MHz core clock; the test clock arrives on a pin and is sampled
package bsp_pkg;
  localparam int N_IO  = 32;
  localparam int N_IN  = 4;
  localparam int N_MC  = 32;
  localparam int BS_IO_IN  = 0;
  localparam int BS_IO_OUT = BS_IO_IN + N_IO;
  localparam int BS_IO_OE  = BS_IO_OUT + N_IO;
  localparam int BS_IN     = BS_IO_OE + N_IO;
  localparam int BS_MC     = BS_IN + N_IN;
  localparam int BS_LEN    = BS_MC + N_MC;
  localparam int SIG_LEN   = 16;
  localparam int GEN_LEN   = 32;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_HIGHZ  = 4'h3;
  localparam logic [3:0] IR_PENTER = 4'h8;
  localparam logic [3:0] IR_CFG    = 4'h9;
  localparam logic [3:0] IR_SIG    = 4'ha;
  localparam logic [3:0] IR_PEXIT  = 4'hb;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPT   = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_SIG  = 4'h8;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_PU    = 1;
  localparam int CTRL_KEEP  = 2;
  localparam int CTRL_FUSE  = 3;
  localparam int CTRL_UNLCK = 4;
  localparam int STAT_PROG  = 0;
  localparam int STAT_LOCK  = 1;
  localparam int STAT_FUSE  = 2;
  localparam int STAT_IR    = 4;
  localparam int STAT_TAP   = 8;
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [31:0] IDCODE_VAL = 32'h0a5a_5001; // arbitrary identity value
  localparam int T_CLK_NS = 10;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
    SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
    UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
    E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
  } bsp_tap_t;
  typedef struct packed {
    logic [N_IO-1:0] out;
    logic [N_IO-1:0] oe_n;
  } bsp_drive_t;
endpackage : bsp_pkg

// [rtl/bsp_port.sv]
// scan test and programming port: test access controller, scan chain, programming lock
// assumes test pins are asynchronous to clk and the test clock is far slower than clk
`timescale 1ns/1ps
module bsp_port import bsp_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // test pins: 0 clock, 1 mode select, 2 data in, 3 data out
  input  wire logic [3:0]        tpin_in,
  output logic [3:0]             tpin_out,
  output logic [3:0]             tpin_oe_n,
  output logic [1:0]             tpin_pullup,
  // user pins
  input  wire logic [N_IO-1:0]   io_in,
  output logic [N_IO-1:0]        io_out,
  output logic [N_IO-1:0]        io_oe_n,
  input  wire logic [N_IN-1:0]   in_pin,
  // core logic side
  input  wire logic [N_IO-1:0]   core_out,
  input  wire logic [N_IO-1:0]   core_oe_n,
  input  wire logic [N_MC-1:0]   core_mc,
  input  wire logic [3:0]        core_tp_out,
  input  wire logic [3:0]        core_tp_oe_n,
  output logic [N_MC-1:0]        mc_update,
  output logic [31:0]            cfg_pattern
);
  logic [3:0]        tp_s1, tp_s2;
  logic              tck_d;
  logic [N_IO-1:0]   io_s1, io_s2;
  logic [N_IN-1:0]   in_s1, in_s2;
  bsp_tap_t          tap;
  logic [3:0]        ir, ir_sh;
  logic [BS_LEN-1:0] bs_sh;
  logic [GEN_LEN-1:0] gen_sh;
  logic              byp;
  logic [N_IO-1:0]   upd_out, upd_oe_n;
  logic [SIG_LEN-1:0] sig;
  logic [3:0]        ctrl;
  logic              fuse, prog, locked;

  function automatic bsp_tap_t tap_step(input bsp_tap_t s, input logic m);
    case (s)
      TLR: tap_step = m ? TLR : RTI;
      RTI: tap_step = m ? SDS : RTI;
      SDS: tap_step = m ? SIS : CDR;
      CDR: tap_step = m ? E1D : SDR;
      SDR: tap_step = m ? E1D : SDR;
      E1D: tap_step = m ? UDR : PDR;
      PDR: tap_step = m ? E2D : PDR;
      E2D: tap_step = m ? UDR : SDR;
      UDR: tap_step = m ? SDS : RTI;
      SIS: tap_step = m ? TLR : CIR;
      CIR: tap_step = m ? E1I : SIR;
      SIR: tap_step = m ? E1I : SIR;
      E1I: tap_step = m ? UIR : PIR;
      PIR: tap_step = m ? E2I : PIR;
      E2I: tap_step = m ? UIR : SIR;
      UIR: tap_step = m ? SDS : RTI;
      default: tap_step = TLR;
    endcase
  endfunction : tap_step

  // pins from outside pass two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tp_s1 <= 4'h0;
      tp_s2 <= 4'h0;
      tck_d <= 1'b0;
      io_s1 <= '0;
      io_s2 <= '0;
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      tp_s1 <= tpin_in;
      tp_s2 <= tp_s1;
      tck_d <= tp_s2[0];
      io_s1 <= io_in;
      io_s2 <= io_s1;
      in_s1 <= in_pin;
      in_s2 <= in_s1;
    end
  end

  wire jtag_en  = ctrl[CTRL_EN];
  wire tck_rise = jtag_en & tp_s2[0] & ~tck_d;
  wire tck_fall = jtag_en & ~tp_s2[0] & tck_d;
  wire tms      = tp_s2[1];
  wire tdi      = tp_s2[2];

  // strobes decoded from the controller state at a rising test clock
  wire cap_dr = tck_rise & (tap == CDR);
  wire sh_dr  = tck_rise & (tap == SDR);
  wire up_dr  = tck_rise & (tap == UDR);
  wire cap_ir = tck_rise & (tap == CIR);
  wire sh_ir  = tck_rise & (tap == SIR);
  wire up_ir  = tck_rise & (tap == UIR);

  // unknown codes fall back to bypass
  wire sel_bs  = (ir == IR_EXTEST) | (ir == IR_SAMPLE);
  wire sel_id  = (ir == IR_IDCODE);
  wire sel_cfg = (ir == IR_CFG);
  wire sel_sig = (ir == IR_SIG);
  wire sel_gen = sel_id | sel_cfg | sel_sig;
  wire extest  = (ir == IR_EXTEST);
  wire highz   = (ir == IR_HIGHZ);

  // a disabled port holds the controller in reset; power-up is arst_n
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      tap <= TLR;
    else if (!jtag_en)
      tap <= TLR;
    else if (tck_rise)
      tap <= tap_step(tap, tms);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir    <= IR_IDCODE;
      ir_sh <= 4'h0;
    end else if (tap == TLR) begin
      ir    <= IR_IDCODE;
    end else if (cap_ir) begin
      ir_sh <= IR_CAPT;
    end else if (sh_ir) begin
      ir_sh <= {tdi, ir_sh[3:1]};
    end else if (up_ir) begin
      ir    <= ir_sh;
    end
  end

  // one chain: macrocell cells, input cells, io cells, tdi to tdo
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      bs_sh <= '0;
    else if (cap_dr && sel_bs)
      bs_sh <= {core_mc, in_s2, core_oe_n, core_out, io_s2};
    else if (sh_dr && sel_bs)
      bs_sh <= {tdi, bs_sh[BS_LEN-1:1]};
  end

  // io out and enable cells and macrocell cells load in one update stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upd_out   <= '0;
      upd_oe_n  <= '1;
      mc_update <= '0;
    end else if (up_dr && sel_bs) begin
      upd_out   <= bs_sh[BS_IO_OUT +: N_IO];
      upd_oe_n  <= bs_sh[BS_IO_OE +: N_IO];
      mc_update <= bs_sh[BS_MC +: N_MC];
    end
  end

  // fuse blanks pattern capture but never the signature
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      gen_sh <= '0;
    else if (cap_dr && sel_id)
      gen_sh <= IDCODE_VAL;
    else if (cap_dr && sel_cfg)
      gen_sh <= fuse ? 32'h0000_0000 : cfg_pattern;
    else if (cap_dr && sel_sig)
      gen_sh <= {16'h0000, sig};
    else if (sh_dr && sel_sig)
      gen_sh <= {16'h0000, tdi, gen_sh[SIG_LEN-1:1]};
    else if (sh_dr && sel_gen)
      gen_sh <= {tdi, gen_sh[GEN_LEN-1:1]};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      byp <= 1'b0;
    else if (cap_dr)
      byp <= 1'b0;
    else if (sh_dr)
      byp <= tdi;
  end

  // programming session; leaving it other than by exit locks the part
  wire prog_abort = prog & ((tap == TLR) | !jtag_en);
  wire unlock     = avs_write & ~avs_waitrequest & (avs_address == ADDR_CTRL) & avs_writedata[CTRL_UNLCK];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog        <= 1'b0;
      locked      <= 1'b0;
      cfg_pattern <= '0;
      sig         <= '0;
    end else begin
      if (prog_abort)
        prog <= 1'b0;
      else if (up_ir && ir_sh == IR_PENTER)
        prog <= 1'b1;
      else if (up_ir && ir_sh == IR_PEXIT)
        prog <= 1'b0;
      if (prog_abort)
        locked <= 1'b1;
      else if (unlock)
        locked <= 1'b0;
      if (up_dr && sel_cfg && prog)
        cfg_pattern <= gen_sh;
      if (up_dr && sel_sig && prog)
        sig <= gen_sh[SIG_LEN-1:0];
    end
  end

  // pin drive priority: lock, programming, extest, highz, core
  bsp_drive_t next_drv;
  bsp_drive_t drv_hold, drv_float, drv_scan, drv_core;
  wire keep = ctrl[CTRL_KEEP];
  // named candidates keep the patterns in a typed context
  assign drv_hold  = '{out: io_out, oe_n: io_oe_n};
  assign drv_float = '{out: io_out, oe_n: '1};
  assign drv_scan  = '{out: upd_out, oe_n: upd_oe_n};
  assign drv_core  = '{out: core_out, oe_n: core_oe_n};
  assign next_drv = locked ? drv_float :
                    prog ? (keep ? drv_hold : drv_float) :
                    extest ? drv_scan :
                    highz ? drv_float :
                    drv_core;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_out  <= '0;
      io_oe_n <= '1;
    end else begin
      io_out  <= next_drv.out;
      io_oe_n <= next_drv.oe_n;
    end
  end

  // tdo moves on the falling test clock, driven only while shifting
  wire shifting = (tap == SDR) | (tap == SIR);
  wire tdo_bit  = (tap == SIR) ? ir_sh[0] : sel_bs ? bs_sh[0] : sel_gen ? gen_sh[0] : byp;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tpin_out  <= 4'h0;
      tpin_oe_n <= 4'hf;
    end else if (jtag_en) begin
      tpin_oe_n[2:0] <= 3'h7;
      if (tck_fall) begin
        tpin_out[3]  <= tdo_bit;
        tpin_oe_n[3] <= ~shifting;
      end
    end else begin
      tpin_out  <= core_tp_out;
      tpin_oe_n <= core_tp_oe_n;
    end
  end

  // avalon slave: every access waits exactly one cycle
  wire         acc = (avs_read | avs_write) & avs_waitrequest;
  // fuse reads back at its own bit; the unlock bit is write-only and reads 0
  wire [31:0]  next_rd = (avs_address == ADDR_CTRL) ? {27'h0, 1'b0, fuse, ctrl[CTRL_KEEP:CTRL_EN]} :
                         (avs_address == ADDR_STAT) ? {8'h00, tap, ir, 1'b0, fuse, locked, prog} :
                         (avs_address == ADDR_SIG)  ? {16'h0000, sig} : 32'h0000_0000;
  wire         ctrl_wr = avs_write & ~avs_waitrequest & (avs_address == ADDR_CTRL);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      ctrl            <= CTRL_RST;
      fuse            <= 1'b0;
      tpin_pullup     <= 2'h0;
    end else begin
      avs_waitrequest <= ~acc;
      if (acc && avs_read)
        avs_readdata <= next_rd;
      if (ctrl_wr) begin
        ctrl <= {1'b0, avs_writedata[CTRL_KEEP:CTRL_EN]};
        fuse <= fuse | avs_writedata[CTRL_FUSE];
      end
      tpin_pullup <= {2{ctrl[CTRL_PU]}};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_tap_reset_off: assert property (!jtag_en |=> tap == TLR)
    else $error("controller left reset while port disabled");
  a_ir_update: assert property (up_ir |=> ir == $past(ir_sh))
    else $error("instruction not loaded at update");
  a_chain_shift: assert property (sh_dr && sel_bs |=> bs_sh[BS_LEN-1] == $past(tdi))
    else $error("chain did not take tdi");
  a_capture_pins: assert property (cap_dr && sel_bs |=> bs_sh[BS_MC +: N_MC] == $past(core_mc))
    else $error("macrocell capture wrong");
  a_update_cells: assert property (up_dr && sel_bs |=> upd_out == $past(bs_sh[BS_IO_OUT +: N_IO]))
    else $error("update stage not loaded");
  a_fuse_blank: assert property (cap_dr && sel_cfg && fuse |=> gen_sh == 32'h0000_0000)
    else $error("pattern readable with fuse set");
  a_sig_open: assert property (cap_dr && sel_sig |=> gen_sh[SIG_LEN-1:0] == $past(sig))
    else $error("signature not readable");
  a_lock_float: assert property (prog_abort |=> locked ##1 io_oe_n == '1)
    else $error("interrupted programming did not float pins");
  a_keep_level: assert property (prog && keep && !locked |=> $stable(io_out) && $stable(io_oe_n))
    else $error("keeper level changed while programming");
  a_free_pins: assert property (!jtag_en ##1 !jtag_en |-> tpin_out == $past(core_tp_out))
    else $error("test pins not freed");
  a_pullup_opt: assert property (ctrl[CTRL_PU] |=> tpin_pullup == 2'h3)
    else $error("pull-up option not applied");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_extest: cover property (up_dr && extest);
  c_prog_done: cover property (up_ir && prog && ir_sh == IR_PEXIT);
  c_lock: cover property (prog_abort);
endmodule : bsp_port

// [verification/bsp_host.sv]
// far-side model: test host that steps the test clock, mode select and data in
// assumes clk at 100 MHz; one test clock period is 8 clk (80 ns)
`timescale 1ns/1ps
module bsp_host (
  // clock
  input  wire logic  clk,
  // test pins
  output logic       tck,
  output logic       tms,
  output logic       tdi,
  input  wire logic  tdo
);
  logic [131:0] res = '0;
  logic         done = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // mode and data move at the falling test clock, data out is taken at the rising one
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    q = tdo;
    repeat (3) @(posedge clk);
  endtask : step
  // data in is toggled outside shifts so that a stale level is never mistaken for data
  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(ms[i], ~tdi, q);
  endtask : walk
  // from idle: select, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [131:0] din, input logic chk);
    logic q;
    res = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      res[i] = q;
    end
    walk(8'h01, 2);
    if (chk) done = ~done;
  endtask : scan
endmodule : bsp_host

// [verification/testbench.sv]
// self-checking bench of the scan test and programming port
// assumes bsp_host on the test pins; reads and scan results are checked oldest first
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench;
  import bsp_pkg::*;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [3:0]       avs_address = '0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = '0;
  logic [31:0]      avs_readdata, cfg_pattern, c;
  logic             avs_waitrequest, tck, tms, tdi, tdo;
  logic [3:0]       tpin_out, tpin_oe_n, core_tp_out, core_tp_oe_n;
  logic [1:0]       tpin_pullup;
  logic [N_IO-1:0]  io_in, io_out, io_oe_n, core_out, core_oe_n;
  logic [N_IN-1:0]  in_pin;
  logic [N_MC-1:0]  core_mc, mc_update;
  logic [15:0]      s;
  logic [63:0]      held;
  logic [159:0]     r;
  logic [131:0]     p, e_rd, e_sc;
  logic [131:0]     exp_q[$];
  logic             tdo_last_n = 1'b1;
  int               err_total = 0;
  int               n_compared = 0;
  always #5 clk = ~clk;
  // a released data out line shows the inverse of its last level, not a kept value
  always @(posedge clk) if (!tpin_oe_n[3]) tdo_last_n <= ~tpin_out[3];
  assign tdo = tpin_oe_n[3] ? tdo_last_n : tpin_out[3];
  bsp_port dut_u (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .tpin_in({tdo, tdi, tms, tck}), .tpin_out, .tpin_oe_n, .tpin_pullup, .io_in, .io_out, .io_oe_n, .in_pin,
    .core_out, .core_oe_n, .core_mc, .core_tp_out, .core_tp_oe_n, .mc_update, .cfg_pattern
  );
  bsp_host hst (.clk, .tck, .tms, .tdi, .tdo);
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      e_rd = exp_q.pop_front();
      `CHK({100'h0, avs_readdata}, e_rd)
    end
  end
  always @(hst.done) begin
    e_sc = exp_q.pop_front();
    `CHK(hst.res, e_sc)
  end
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      err_total++;
      finish_test();
    end
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back({100'h0, e});
    bus(1'b0, a, '0);
  endtask : rd
  task automatic sc(input int n, input logic [131:0] din, input logic [131:0] e);
    exp_q.push_back(e);
    hst.scan(1'b0, n, din, 1'b1);
    repeat (4) @(posedge clk);
  endtask : sc
  task automatic ir(input logic [3:0] code);
    hst.scan(1'b1, 4, {128'h0, code}, 1'b0);
    repeat (4) @(posedge clk);
  endtask : ir
  initial begin
    #200_000;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(50366));
    io_in = $urandom();
    in_pin = 4'($urandom());
    core_out = $urandom();
    core_oe_n = $urandom();
    core_mc = $urandom();
    core_tp_out = 4'($urandom());
    core_tp_oe_n = 4'($urandom());
    r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
    p = r[131:0];
    c = $urandom();
    s = 16'($urandom());
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_STAT, 32'h0000_0120); // reset state, identity instruction
    rd(ADDR_CTRL, 32'h1);
    rd(4'hc, 32'h0);
    hst.walk(8'h00, 1);
    sc(32, '0, {100'h0, IDCODE_VAL});
    ir(IR_BYPASS);
    sc(8, 132'hb5, 132'h6a); // one-bit delay, captures zero
    bus(1'b1, ADDR_CTRL, 32'h5);
    held = {core_oe_n, core_out};
    ir(IR_PENTER);
    core_out <= ~core_out;
    repeat (3) @(posedge clk);
    `CHK({io_oe_n, io_out}, held)
    ir(IR_CFG);
    sc(32, {100'h0, c}, 132'h0);
    `CHK(cfg_pattern, c)
    rd(ADDR_STAT, 32'h0000_0291);
    ir(IR_SIG);
    hst.scan(1'b0, 16, {116'h0, s}, 1'b0);
    rd(ADDR_SIG, {16'h0, s});
    bus(1'b1, ADDR_CTRL, 32'hd);
    rd(ADDR_CTRL, 32'hd);
    ir(IR_CFG);
    sc(32, '0, '0); // pattern hidden once the fuse is set
    ir(IR_SIG);
    sc(16, {116'h0, s}, {116'h0, s}); // signature still readable
    hst.walk(8'h1f, 6);
    repeat (4) @(posedge clk);
    `CHK(io_oe_n, {N_IO{1'b1}})
    ir(IR_PEXIT);
    bus(1'b1, ADDR_CTRL, 32'h19);
    rd(ADDR_STAT, 32'h0000_02b4);
    `CHK(io_oe_n, core_oe_n)
    ir(IR_SAMPLE);
    sc(132, p, {core_mc, in_pin, core_oe_n, core_out, io_in});
    `CHK(io_out, core_out)
    ir(IR_EXTEST);
    `CHK({mc_update, io_oe_n, io_out}, {p[131:100], p[95:64], p[63:32]})
    ir(IR_HIGHZ);
    `CHK(io_oe_n, {N_IO{1'b1}})
    bus(1'b1, ADDR_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    `CHK({tpin_pullup, tpin_oe_n, tpin_out}, {2'b11, core_tp_oe_n, core_tp_out})
    finish_test();
  end
endmodule : testbench
